// ===== core/csm_ctrl.v
// Supervisory charge control: supply mode, panel gating, retry pause, stages.
// Assumes digitised measurements in mV/mA arrive on pins from an outside converter.
`timescale 1ns/100ps
`default_nettype none
`include "csm_defs.vh"
module csm_ctrl #(
	parameter W          = `CSM_MEAS_W,
	parameter RETRY_CYC  = `CSM_CLK_HZ * `CSM_RETRY_S,
	parameter SAMPLE_CYC = `CSM_SAMPLE_CYC
) (
	input  wire         core_clk,
	input  wire         resetn,
	input  wire [W-1:0] input_voltage_sense_pin,
	input  wire [W-1:0] panel_mv,
	input  wire [W-1:0] panel_ma,
	input  wire [W-1:0] panel_ma_min,
	input  wire [W-1:0] bat_mv,
	input  wire [W-1:0] stage2_limit_mv,
	input  wire [W-1:0] charge_ma,
	input  wire [W-1:0] c10_ma,
	input  wire [W-1:0] s0_limit_mv,
	input  wire [W-1:0] s1_limit_mv,
	input  wire         low_power_en,
	input  wire         stage3_en,
	input  wire         timer_term_req,
	output reg          supply_mode,
	output reg          timer_term_en,
	output reg          charge_en,
	output reg          uv_fault,
	output reg          retry_pause,
	output reg  [1:0]   stage,
	output reg          mppt_en
);
	// One-hot states of the panel current check
	localparam ST_IDLE  = 3'b001;
	localparam ST_RUN   = 3'b010;
	localparam ST_PAUSE = 3'b100;

	wire [W-1:0] s_sense;
	wire [W-1:0] s_pv;
	wire [W-1:0] s_pi;
	wire [W-1:0] s_bat;
	wire [W-1:0] s_ich;
	wire [2:0]   s_bits;
	reg  [2:0]   state;
	reg  [31:0]  retry_cnt;
	reg  [15:0]  smp_cnt;
	reg          lp_armed;
	reg  [W-1:0] pv_ref;
	reg  [W-1:0] bat_ref;
	wire [W+6:0] uv_fall = stage2_limit_mv * `CSM_UV_FALL_PCT;
	wire [W+6:0] uv_rise = stage2_limit_mv * `CSM_UV_RISE_PCT;
	wire [W+6:0] bat_x100 = s_bat * 7'h64;
	wire         tick = (smp_cnt == 16'h0000);
	wire         pv_ok = (s_pv >= `CSM_VIN_MIN_MV);
	wire         cur_ok = (s_pi >= panel_ma_min);
	// Extra top bit keeps the margin sums from wrapping near full scale
	wire         pv_rise = ({1'b0, s_pv} > {1'b0, pv_ref} + `CSM_PV_RISE_MV);
	wire         bat_fall = ({1'b0, bat_ref} > {1'b0, s_bat} + `CSM_BAT_FALL_MV);
	wire         low_i = (s_ich < c10_ma);
	wire         ps_now = (s_sense < `CSM_SENSE_PS_MV);
	reg          next_uv_fault;
	reg          pause_go;

	////////////////////////////////////////////////////////////////
	// Pin-side measurements pass through synchronisers
	csm_sync #(.W(W)) u_sense (.core_clk(core_clk), .resetn(resetn), .din(input_voltage_sense_pin), .dout(s_sense));
	csm_sync #(.W(W)) u_pv    (.core_clk(core_clk), .resetn(resetn), .din(panel_mv), .dout(s_pv));
	csm_sync #(.W(W)) u_pi    (.core_clk(core_clk), .resetn(resetn), .din(panel_ma), .dout(s_pi));
	csm_sync #(.W(W)) u_bat   (.core_clk(core_clk), .resetn(resetn), .din(bat_mv), .dout(s_bat));
	csm_sync #(.W(W)) u_ich   (.core_clk(core_clk), .resetn(resetn), .din(charge_ma), .dout(s_ich));
	csm_sync #(.W(3)) u_bits  (.core_clk(core_clk), .resetn(resetn),
		.din({low_power_en, stage3_en, timer_term_req}), .dout(s_bits));

	////////////////////////////////////////////////////////////////
	// Sample tick paces every decision
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			smp_cnt <= 16'h0000;
		else if (tick)
			smp_cnt <= SAMPLE_CYC[15:0] - 16'h0001;
		else
			smp_cnt <= smp_cnt - 16'h0001;
	end

	////////////////////////////////////////////////////////////////
	// Fault and pause verdicts for this tick; the registered enables
	// read them so charging stops in the same tick as the cause
	always @*
	begin
		// Hysteresis: enter below 31%, leave above 35%
		if (bat_x100 < uv_fall)
			next_uv_fault = 1'b1;
		else if (bat_x100 > uv_rise)
			next_uv_fault = 1'b0;
		else
			next_uv_fault = uv_fault;
		// Weak panel current pauses only in panel mode without low power
		pause_go = (state == ST_RUN) & pv_ok & ~ps_now & ~s_bits[2] & ~cur_ok;
	end

	////////////////////////////////////////////////////////////////
	// Mode, fault and enables, refreshed on each tick
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			supply_mode   <= 1'b0;
			timer_term_en <= 1'b0;
			mppt_en       <= 1'b0;
			uv_fault      <= 1'b1;
			lp_armed      <= 1'b0;
			charge_en     <= 1'b0;
		end
		else if (tick)
		begin
			supply_mode   <= ps_now;
			// Timers are unreliable when light can vanish mid-cycle
			timer_term_en <= ps_now & s_bits[0];
			mppt_en       <= ~ps_now & pv_ok;
			// Hysteresis decided above, so fault and halt share a tick
			uv_fault      <= next_uv_fault;
			if (!pv_ok)
				lp_armed <= 1'b0;
			else if (s_pv > `CSM_VIN_LOWPWR_MV)
				lp_armed <= 1'b1;
			if (ps_now)
				charge_en <= pv_ok & ~next_uv_fault;
			else
				charge_en <= pv_ok & ~next_uv_fault & (state == ST_RUN) & ~pause_go
					& (~s_bits[2] | lp_armed);
		end
	end

	////////////////////////////////////////////////////////////////
	// Panel current check and timed retry
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state     <= ST_IDLE;
			retry_cnt <= 32'h0;
			pv_ref    <= {W{1'b0}};
			bat_ref   <= {W{1'b0}};
		end
		else if (tick)
		begin
			case (state)
				ST_IDLE:
					if (pv_ok)
						state <= ST_RUN;
				ST_RUN:
					if (!pv_ok)
						state <= ST_IDLE;
					else if (pause_go)
					begin
						state     <= ST_PAUSE;
						retry_cnt <= RETRY_CYC[31:0];
						pv_ref    <= s_pv;
						bat_ref   <= s_bat;
					end
				ST_PAUSE:
					// Early retry on a big change in panel or battery
					if (retry_cnt <= {16'h0, SAMPLE_CYC[15:0]} || pv_rise || bat_fall || ps_now)
						state <= ST_RUN;
					else
						retry_cnt <= retry_cnt - {16'h0, SAMPLE_CYC[15:0]};
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Pause status decodes straight from the state register
	always @*
		retry_pause = (state == ST_PAUSE);

	////////////////////////////////////////////////////////////////
	// Charging stage tracking
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			stage <= `CSM_ST_S0;
		else if (tick)
		begin
			if (uv_fault)
				stage <= `CSM_ST_S0;
			else
				case (stage)
					`CSM_ST_S0:
						if (s_bat > s0_limit_mv)
							stage <= `CSM_ST_S1;
					`CSM_ST_S1:
						if (s_bat > s1_limit_mv)
							stage <= `CSM_ST_S2;
					`CSM_ST_S2:
						// Low current with ample panel means nearly full
						if (low_i && (ps_now || cur_ok) && s_bits[1])
							stage <= `CSM_ST_S3;
						else
							stage <= `CSM_ST_S2;
					default:
						stage <= stage;
				endcase
		end
	end
endmodule
`default_nettype wire

// ===== core/csm_defs.vh
// Constants for the charger supply mode control block.
// Assumes measurement codes share one scale: 1 LSB = 1 mV.
`ifndef CSM_DEFS_VH
`define CSM_DEFS_VH
`define CSM_MEAS_W        16
`define CSM_SENSE_PS_MV   16'h00AE
`define CSM_VIN_MIN_MV    16'h1770
`define CSM_VIN_LOWPWR_MV 16'h2710
`define CSM_UV_FALL_PCT   7'h1F
`define CSM_UV_RISE_PCT   7'h23
`define CSM_CLK_HZ        50000000
`define CSM_RETRY_S       30
`define CSM_PV_RISE_MV    16'h03E8
`define CSM_BAT_FALL_MV   16'h01F4
`define CSM_SAMPLE_CYC    16'h03E8
`define CSM_ST_S0         2'h0
`define CSM_ST_S1         2'h1
`define CSM_ST_S2         2'h2
`define CSM_ST_S3         2'h3
`endif

// ===== core/csm_sync.v
// Three-stage input synchroniser for a multi-bit sampled value.
// Assumes the value is held stable long enough for stages two and three to agree.
`timescale 1ns/100ps
`default_nettype none
module csm_sync #(
	parameter W = 1
) (
	input  wire         core_clk,
	input  wire         resetn,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;

	// Only a value on which stages two and three agree is passed on
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1   <= {W{1'b0}};
			s2   <= {W{1'b0}};
			s3   <= {W{1'b0}};
			dout <= {W{1'b0}};
		end
		else
		begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				dout <= s3;
		end
	end
endmodule
`default_nettype wire

// ===== tb/csm_sva.sv
// Checker on csm_ctrl ports.
// Assumes bind into csm_ctrl.
`timescale 1ns/100ps
`default_nettype none
module csm_sva #(
	parameter W          = 16,
	parameter RETRY_CYC  = 300,
	parameter SAMPLE_CYC = 8
) (
	input wire         core_clk,
	input wire         resetn,
	input wire [W-1:0] bat_mv,
	input wire [W-1:0] stage2_limit_mv,
	input wire         supply_mode,
	input wire         timer_term_en,
	input wire         charge_en,
	input wire         uv_fault,
	input wire         retry_pause,
	input wire [1:0]   stage,
	input wire         mppt_en
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (!resetn);
// Pause length; a dead retry timer holds it
reg [31:0] pcnt;
always @(posedge core_clk or negedge resetn)
	if (!resetn)
		pcnt <= 32'h0;
	else
		pcnt <= retry_pause ? pcnt + 32'h1 : 32'h0;
////////////////////
chk_supply_mppt: assert property (supply_mode |-> !mppt_en)
	else $error("mppt on in supply mode");
chk_timer_panel: assert property (timer_term_en |-> supply_mode)
	else $error("timer on in panel mode");
chk_uv_halt: assert property (uv_fault |-> !charge_en)
	else $error("charging in fault");
chk_pause_halt: assert property (retry_pause |-> !charge_en)
	else $error("charging in pause");
chk_pause_bound: assert property (pcnt <= RETRY_CYC + 4 * SAMPLE_CYC + 8)
	else $error("pause too long");
chk_stage3_entry: assert property (stage == 2'h3 && $past(stage) != 2'h3 |-> $past(stage) == 2'h2)
	else $error("stage 3 not from 2");
chk_pause_panel: assert property ($rose(retry_pause) |-> !supply_mode)
	else $error("pause in supply mode");
chk_uv_release: assert property ($fell(uv_fault) |-> {16'h0, bat_mv} * 32'h64 > {16'h0, stage2_limit_mv} * 32'h23)
	else $error("fault left too low");
cover property (supply_mode);
cover property ($rose(retry_pause));
cover property (stage == 2'h3);
endmodule
`default_nettype wire

// ===== tb/csm_env.sv
// Panel and battery model.
// Assumes bench sets the operating point.
`timescale 1ns/100ps
`default_nettype none
module csm_env (
	input  wire logic [15:0] pa_set,
	input  wire logic [15:0] cm_set,
	input  wire logic        charge_en,
	output logic      [15:0] panel_ma,
	output logic      [15:0] charge_ma
);
// Battery current flows only while charging
assign panel_ma = pa_set;
assign charge_ma = charge_en ? cm_set : 16'h0000;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Bench for csm_ctrl.
// Assumes short sample and retry counts.
`timescale 1ns/100ps
`default_nettype none
module tb;
localparam RC = 300;
localparam SC = 8;
logic core_clk = 1'b0, resetn = 1'b0, lp = 1'b0, s3 = 1'b0, tr = 1'b1, sm, tte, ce, uv, rp, mp;
logic [15:0] sense = 16'h03E8, pv = 16'h1F40, pa = 16'h01F4, bv = 16'h1388, cm = 16'h01F4;
logic [15:0] pma, cma;
logic [1:0]  st;
int          bad_count = 0, checks = 0, n;
csm_env i_csm_env (.pa_set(pa), .cm_set(cm), .charge_en(ce), .panel_ma(pma), .charge_ma(cma));
csm_ctrl #(.RETRY_CYC(RC), .SAMPLE_CYC(SC)) i_csm_ctrl (.core_clk(core_clk), .resetn(resetn),
	.input_voltage_sense_pin(sense), .panel_mv(pv), .panel_ma(pma), .panel_ma_min(16'h00C8),
	.bat_mv(bv), .stage2_limit_mv(16'h2EE0), .charge_ma(cma), .c10_ma(16'h0064),
	.s0_limit_mv(16'h20D0), .s1_limit_mv(16'h2DF0), .low_power_en(lp), .stage3_en(s3),
	.timer_term_req(tr), .supply_mode(sm), .timer_term_en(tte), .charge_en(ce),
	.uv_fault(uv), .retry_pause(rp), .stage(st), .mppt_en(mp));
always #10 core_clk = ~core_clk;
////////////////////
task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
	checks++;
	if (s !== e)
	begin
		bad_count++;
		$display("[ERR] %s exp %h got %h", nm, e, s);
	end
endtask
task automatic wt(input int c);
	repeat (c) @(negedge core_clk);
endtask
// Cycles until retry_pause reads v
task automatic until_rp(input logic v, input int lim);
	for (n = 0; n < lim && rp !== v; n++)
		wt(1);
endtask
task automatic t_supply;
	sense = 16'h0000;
	pv = 16'h1770;
	wt(60);
	chk("sm", sm, 1);
	chk("mp", mp, 0);
	chk("tte", tte, 1);
	chk("ce", ce, 1);
	tr = 1'b0;
	wt(30);
	chk("tte", tte, 0);
	tr = 1'b1;
	sense = 16'h00AE;
	pv = 16'h1F40;
	wt(60);
	chk("sm", sm, 0);
	chk("tte", tte, 0);
	chk("mp", mp, 1);
	$display("t_supply done");
endtask
task automatic t_uv;
	logic [15:0] b [4] = '{16'h0BB8, 16'h0FA0, 16'h1388, 16'h0FA0};
	logic        e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	for (int i = 0; i < 4; i++)
	begin
		bv = b[i];
		wt(60);
		chk("uv", uv, e[i]);
		chk("ce", ce, !e[i]);
	end
	bv = 16'h1388;
	$display("t_uv done");
endtask
task automatic t_lp;
	logic [15:0] v [5] = '{16'h1F40, 16'h2AF8, 16'h1F40, 16'h1388, 16'h1F40};
	logic        e [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	lp = 1'b1;
	for (int i = 0; i < 5; i++)
	begin
		pv = v[i];
		wt(60);
		chk("ce", ce, e[i]);
		chk("mp", mp, i != 3);
	end
	lp = 1'b0;
	$display("t_lp done");
endtask
task automatic t_pause;
	pa = 16'h0064;
	wt(60);
	chk("rp", rp, 1);
	chk("ce", ce, 0);
	pv = 16'h251C;
	until_rp(1'b0, 40);
	chk("pv", rp, 0);
	until_rp(1'b1, 60);
	until_rp(1'b0, 600);
	chk("rc", n >= RC - 2 * SC && n <= RC + 4 * SC, 1);
	until_rp(1'b1, 60);
	bv = 16'h1130;
	until_rp(1'b0, 40);
	chk("bv", rp, 0);
	pa = 16'h01F4;
	bv = 16'h1388;
	$display("t_pause done");
endtask
task automatic t_stage;
	bv = 16'h2EE0;
	wt(400);
	chk("st", st, 2);
	cm = 16'h0032;
	wt(60);
	chk("st", st, 2);
	s3 = 1'b1;
	pa = 16'h0064;
	wt(60);
	chk("st", st, 2);
	pa = 16'h01F4;
	wt(400);
	chk("st", st, 3);
	$display("t_stage done");
endtask
task automatic summarize;
	$display("checks %0d bad %0d", checks, bad_count);
	if (bad_count == 0 && checks > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
endtask
initial
begin
	wt(16);
	resetn = 1'b1;
	t_supply;
	t_uv;
	t_lp;
	t_pause;
	t_stage;
	summarize;
end
// Watchdog
initial
begin
	#400000;
	bad_count++;
	summarize;
end
endmodule
bind csm_ctrl csm_sva #(.W(W), .RETRY_CYC(RETRY_CYC), .SAMPLE_CYC(SAMPLE_CYC)) i_csm_sva (
	.core_clk(core_clk), .resetn(resetn), .bat_mv(bat_mv), .stage2_limit_mv(stage2_limit_mv),
	.supply_mode(supply_mode), .timer_term_en(timer_term_en), .charge_en(charge_en),
	.uv_fault(uv_fault), .retry_pause(retry_pause), .stage(stage), .mppt_en(mppt_en));
`default_nettype wire
